// ==== hdl/rtcr_pkg.sv ====
// Constants, field layout and types of the clock/calendar register block.
// Assumes a 25 MHz register clock and a 32-bit AXI4-Lite register port.
// Operation
// - Format bit 0 selects 24-hour counting, 1 selects 12-hour counting.
// - Protect enable blocks writes to control, format, time alarm and date alarm.
// - BCD fields hold units in low four bits, tens above.
// - Seconds and minutes accept BCD 00 to 59.
// - Hours accept 01-12 in 12-hour format, 00-23 in 24-hour format.
// - In 12-hour format meridiem reads 0 morning, 1 afternoon.
// - Hundred-years field accepts only BCD 20.
// - Year accepts BCD 00 to 99.
// - Month accepts BCD 01 to 12.
// - Day-of-week accepts 1 to 7 and never steers date counting.
// - Day-of-month accepts BCD 01 to the last date of its month (28, 29, 30 or 31).
// - Second, minute, hour alarms compare only when enables at 7, 15, 23 set.
// - Date and month alarms compare only when enables at 31, 23 set.
// - Update grant at bit 0 sets once writable, stays until cleared.
// - Alarm flag at bit 1 sets when enabled alarm fields match.
// - Second flag at bit 2 sets on each tick, stays until cleared.
// - Time event flag at bit 3 sets on the chosen minute/hour/noon/midnight event.
// - Writing 1 to a clear command bit clears that flag; 0 does nothing.
// - Calendar event flag sets on the chosen week, month or year change.
// - Time counters are writable only after an update request is granted.
// - Out-of-range writes are not loaded and set a validity flag.
`default_nettype none
package rtcr_pkg;
	// Byte addresses
	localparam logic [31:0] RTCR_OFF_CTRL = 32'h0FFFFEB0;
	localparam logic [31:0] RTCR_OFF_MODE = 32'h0FFFFEB4;
	localparam logic [31:0] RTCR_OFF_TIME = 32'h0FFFFEB8;
	localparam logic [31:0] RTCR_OFF_CAL = 32'h0FFFFEBC;
	localparam logic [31:0] RTCR_OFF_TALM = 32'h0FFFFEC0;
	localparam logic [31:0] RTCR_OFF_DALM = 32'h0FFFFEC4;
	localparam logic [31:0] RTCR_OFF_STAT = 32'h0FFFFEC8;
	localparam logic [31:0] RTCR_OFF_CLR = 32'h0FFFFECC;
	localparam logic [31:0] RTCR_OFF_VALID = 32'h0FFFFEDC;
	localparam logic [31:0] RTCR_OFF_PROT = 32'h0FFFFEE0;
	// Reset values and writable masks
	localparam logic [31:0] RTCR_RST_CAL = 32'h01210720;
	localparam logic [31:0] RTCR_RST_DALM = 32'h01010000;
	localparam logic [31:0] RTCR_TALM_MASK = 32'h00FFFFFF;
	localparam logic [31:0] RTCR_DALM_MASK = 32'hBF9F0000;
	// Field positions
	localparam int RTCR_SEC_LSB = 0;
	localparam int RTCR_MIN_LSB = 8;
	localparam int RTCR_HOUR_LSB = 16;
	localparam int RTCR_PM_BIT = 22;
	localparam int RTCR_SEC_EN = 7;
	localparam int RTCR_MIN_EN = 15;
	localparam int RTCR_HOUR_EN = 23;
	localparam int RTCR_HUNDRED_YEARS_FIELD_LSB = 0;
	localparam int RTCR_YEAR_LSB = 8;
	localparam int RTCR_MONTH_LSB = 16;
	localparam int RTCR_DOW_LSB = 21;
	localparam int RTCR_DATE_LSB = 24;
	localparam int RTCR_MTH_EN = 23;
	localparam int RTCR_DATE_EN = 31;
	localparam int RTCR_HR_BIT = 0;
	localparam int RTCR_WP_BIT = 0;
	localparam int RTCR_UPDT_BIT = 0;
	localparam int RTCR_UPDC_BIT = 1;
	localparam int RTCR_TEV_LSB = 8;
	localparam int RTCR_CEV_LSB = 16;
	localparam int RTCR_ST_ACK = 0;
	localparam int RTCR_ST_ALM = 1;
	localparam int RTCR_ST_SEC = 2;
	localparam int RTCR_ST_TEV = 3;
	localparam int RTCR_ST_CEV = 4;
	localparam int RTCR_NV_TIM = 0;
	localparam int RTCR_NV_CAL = 1;
	localparam int RTCR_NV_TALM = 2;
	localparam int RTCR_NV_DALM = 3;
	// BCD limits
	localparam logic [7:0] RTCR_BCD_00 = 8'h00;
	localparam logic [7:0] RTCR_BCD_01 = 8'h01;
	localparam logic [7:0] RTCR_BCD_07 = 8'h07;
	localparam logic [7:0] RTCR_BCD_11 = 8'h11;
	localparam logic [7:0] RTCR_BCD_12 = 8'h12;
	localparam logic [7:0] RTCR_BCD_20 = 8'h20;
	localparam logic [7:0] RTCR_BCD_23 = 8'h23;
	localparam logic [7:0] RTCR_BCD_28 = 8'h28;
	localparam logic [7:0] RTCR_BCD_29 = 8'h29;
	localparam logic [7:0] RTCR_BCD_30 = 8'h30;
	localparam logic [7:0] RTCR_BCD_31 = 8'h31;
	localparam logic [7:0] RTCR_BCD_59 = 8'h59;
	localparam logic [7:0] RTCR_BCD_99 = 8'h99;
	localparam logic [3:0] RTCR_DIGIT_MAX = 4'h9;
	// Tick timing
	localparam int RTCR_CLK_HZ = 25000000;
	localparam int RTCR_TICK_PERIOD_S = 1;
	localparam int RTCR_SEC_CYCLES = RTCR_CLK_HZ * RTCR_TICK_PERIOD_S;
	localparam int RTCR_CNT_W = 25;
	// Bus answers
	localparam logic [1:0] RTCR_RESP_OKAY = 2'h0;
	localparam logic [1:0] RTCR_RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		RTCR_TEV_MINUTE = 2'h0,
		RTCR_TEV_HOUR = 2'h1,
		RTCR_TEV_MIDNIGHT = 2'h2,
		RTCR_TEV_NOON = 2'h3
	} rtcr_tev_t;
	typedef enum logic [1:0] {
		RTCR_CEV_WEEK = 2'h0,
		RTCR_CEV_MONTH = 2'h1,
		RTCR_CEV_YEAR = 2'h2,
		RTCR_CEV_NONE = 2'h3
	} rtcr_cev_t;
endpackage : rtcr_pkg
`default_nettype wire

// ==== hdl/rtcr_regs.sv ====
// Clock/calendar counters, alarms, event flags and their AXI4-Lite register port.
// Assumes one 25 MHz clock, synchronous bus inputs and a master with one access of each kind in flight.
`default_nettype none
module rtcr_regs
	import rtcr_pkg::*;
#(
	parameter int unsigned SEC_CYCLES = RTCR_SEC_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [31:0] axi_awaddr_i,
	input wire logic axi_awvalid_i,
	output logic axi_awready_o,
	input wire logic [31:0] axi_wdata_i,
	input wire logic [3:0] axi_wstrb_i,
	input wire logic axi_wvalid_i,
	output logic axi_wready_o,
	output logic [1:0] axi_bresp_o,
	output logic axi_bvalid_o,
	input wire logic axi_bready_i,
	input wire logic [31:0] axi_araddr_i,
	input wire logic axi_arvalid_i,
	output logic axi_arready_o,
	output logic [31:0] axi_rdata_o,
	output logic [1:0] axi_rresp_o,
	output logic axi_rvalid_o,
	input wire logic axi_rready_i
);
	// BCD helpers
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		bcd_inc = (v[3:0] == RTCR_DIGIT_MAX) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
	endfunction : bcd_inc

	function automatic logic bcd_ok(input logic [7:0] v);
		bcd_ok = (v[3:0] <= RTCR_DIGIT_MAX) && (v[7:4] <= RTCR_DIGIT_MAX);
	endfunction : bcd_ok

	function automatic logic in_rng(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
		in_rng = bcd_ok(v) && (v >= lo) && (v <= hi); // Valid BCD orders like binary
	endfunction : in_rng

	// Last date of a month; century fixed, so every fourth year is leap
	function automatic logic [7:0] month_days(input logic [7:0] mon, input logic [7:0] yr);
		logic leap;
		leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) : (yr[1:0] == 2'h0);
		if (mon == 8'h02) begin
			month_days = leap ? RTCR_BCD_29 : RTCR_BCD_28;
		end else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11) begin
			month_days = RTCR_BCD_30;
		end else begin
			month_days = RTCR_BCD_31;
		end
	endfunction : month_days

	// Hour check depends on the format in force
	function automatic logic hour_ok(input logic [7:0] hr, input logic pm, input logic h12);
		hour_ok = h12 ? in_rng(hr, RTCR_BCD_01, RTCR_BCD_12) : (in_rng(hr, RTCR_BCD_00, RTCR_BCD_23) && !pm);
	endfunction : hour_ok

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		merge = (old & ~m) | (nw & m);
	endfunction : merge

	logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic [31:0] rdata_ff, waddr_ff, wdata_ff;
	logic [3:0] wstrb_ff;
	logic aw_got_ff, w_got_ff;
	logic hr12_ff, wp_ff, upd_tim_ff, upd_cal_ff, granted_ff, tick_ff;
	rtcr_tev_t tev_ff;
	rtcr_cev_t cev_ff;
	logic [RTCR_CNT_W-1:0] div_ff;
	logic [7:0] sec_ff, min_ff, hour_ff, hundred_years_field_ff, year_ff, month_ff, date_ff;
	logic pm_ff;
	logic [2:0] dow_ff;
	logic [31:0] talm_ff, dalm_ff;
	logic ack_ff, alm_ff, secf_ff, tevf_ff, cevf_ff;
	logic [3:0] nv_ff;

	// Read views of the time, calendar, control and status words
	logic [31:0] time_rd, cal_rd, ctrl_rd, stat_rd;
	assign time_rd = {8'h00, 1'b0, pm_ff, hour_ff[5:0], 1'b0, min_ff[6:0], 1'b0, sec_ff[6:0]};
	assign cal_rd = {2'h0, date_ff[5:0], dow_ff, month_ff[4:0], year_ff, 1'b0, hundred_years_field_ff[6:0]};
	always_comb begin
		ctrl_rd = 32'h00000000;
		ctrl_rd[RTCR_UPDT_BIT] = upd_tim_ff;
		ctrl_rd[RTCR_UPDC_BIT] = upd_cal_ff;
		ctrl_rd[RTCR_TEV_LSB +: 2] = tev_ff;
		ctrl_rd[RTCR_CEV_LSB +: 2] = cev_ff;
		stat_rd = 32'h00000000;
		stat_rd[RTCR_ST_ACK] = ack_ff;
		stat_rd[RTCR_ST_ALM] = alm_ff;
		stat_rd[RTCR_ST_SEC] = secf_ff;
		stat_rd[RTCR_ST_TEV] = tevf_ff;
		stat_rd[RTCR_ST_CEV] = cevf_ff;
	end

	// Address decode shared by reads and write merging; bit 32 marks a mapped word
	function automatic logic [32:0] rd_word(input logic [31:0] a);
		if (a == RTCR_OFF_CTRL) begin
			rd_word = {1'b1, ctrl_rd};
		end else if (a == RTCR_OFF_MODE) begin
			rd_word = {1'b1, 31'h0, hr12_ff};
		end else if (a == RTCR_OFF_TIME) begin
			rd_word = {1'b1, time_rd};
		end else if (a == RTCR_OFF_CAL) begin
			rd_word = {1'b1, cal_rd};
		end else if (a == RTCR_OFF_TALM) begin
			rd_word = {1'b1, talm_ff};
		end else if (a == RTCR_OFF_DALM) begin
			rd_word = {1'b1, dalm_ff};
		end else if (a == RTCR_OFF_STAT) begin
			rd_word = {1'b1, stat_rd};
		end else if (a == RTCR_OFF_CLR) begin
			rd_word = {1'b1, 32'h0}; // Write-only, reads zero
		end else if (a == RTCR_OFF_VALID) begin
			rd_word = {1'b1, 28'h0, nv_ff};
		end else if (a == RTCR_OFF_PROT) begin
			rd_word = {1'b1, 31'h0, wp_ff};
		end else begin
			rd_word = {1'b0, 32'h0};
		end
	endfunction : rd_word

	// Bus handshakes
	logic aw_hs, w_hs, ar_hs, do_wr;
	logic nxt_aw_got, nxt_w_got, nxt_bvalid, nxt_rvalid;
	logic [32:0] wr_old, rd_sel;
	logic [31:0] wm;
	assign aw_hs = axi_awvalid_i & awready_ff;
	assign w_hs = axi_wvalid_i & wready_ff;
	assign ar_hs = axi_arvalid_i & arready_ff;
	assign do_wr = aw_got_ff & w_got_ff & !bvalid_ff;
	assign nxt_aw_got = (aw_got_ff | aw_hs) & !do_wr;
	assign nxt_w_got = (w_got_ff | w_hs) & !do_wr;
	assign nxt_bvalid = do_wr | (bvalid_ff & !axi_bready_i);
	assign nxt_rvalid = ar_hs | (rvalid_ff & !axi_rready_i);
	// A process, not assigns: the decode reads live register views beyond its argument
	always_comb begin
		wr_old = rd_word(waddr_ff);
		rd_sel = rd_word(axi_araddr_i);
	end
	assign wm = merge(wr_old[31:0], wdata_ff, wstrb_ff);

	// Write channel; ready drops while a word is held or its answer waits
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			awready_ff <= 1'b0;
			wready_ff <= 1'b0;
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= RTCR_RESP_OKAY;
			waddr_ff <= 32'h00000000;
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
		end else begin
			awready_ff <= !nxt_aw_got & !nxt_bvalid;
			wready_ff <= !nxt_w_got & !nxt_bvalid;
			aw_got_ff <= nxt_aw_got;
			w_got_ff <= nxt_w_got;
			bvalid_ff <= nxt_bvalid;
			if (aw_hs) waddr_ff <= axi_awaddr_i;
			if (w_hs) wdata_ff <= axi_wdata_i;
			if (w_hs) wstrb_ff <= axi_wstrb_i;
			if (do_wr) bresp_ff <= wr_old[32] ? RTCR_RESP_OKAY : RTCR_RESP_SLVERR;
		end
	end

	// Read channel; data captured at the address handshake
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= RTCR_RESP_OKAY;
		end else begin
			arready_ff <= !nxt_rvalid;
			rvalid_ff <= nxt_rvalid;
			if (ar_hs) rdata_ff <= rd_sel[31:0];
			if (ar_hs) rresp_ff <= rd_sel[32] ? RTCR_RESP_OKAY : RTCR_RESP_SLVERR;
		end
	end

	// Write targets; protected words silently keep their value
	logic wr_ctrl, wr_mode, wr_time, wr_cal, wr_talm, wr_dalm, wr_clr, wr_prot;
	assign wr_ctrl = do_wr && waddr_ff == RTCR_OFF_CTRL && !wp_ff;
	assign wr_mode = do_wr && waddr_ff == RTCR_OFF_MODE && !wp_ff;
	assign wr_talm = do_wr && waddr_ff == RTCR_OFF_TALM && !wp_ff;
	assign wr_dalm = do_wr && waddr_ff == RTCR_OFF_DALM && !wp_ff;
	assign wr_time = do_wr && waddr_ff == RTCR_OFF_TIME && upd_tim_ff && granted_ff;
	assign wr_cal = do_wr && waddr_ff == RTCR_OFF_CAL && upd_cal_ff && granted_ff;
	assign wr_clr = do_wr && waddr_ff == RTCR_OFF_CLR;
	assign wr_prot = do_wr && waddr_ff == RTCR_OFF_PROT;

	// Field checks on the merged write word
	logic [7:0] w_sec, w_min, w_hour, w_hundred_years_field, w_year, w_month, w_date;
	logic [2:0] w_dow;
	logic time_ok, cal_ok, talm_ok, dalm_ok;
	assign w_sec = {1'b0, wm[RTCR_SEC_LSB +: 7]};
	assign w_min = {1'b0, wm[RTCR_MIN_LSB +: 7]};
	assign w_hour = {2'h0, wm[RTCR_HOUR_LSB +: 6]};
	assign w_hundred_years_field = {1'b0, wm[RTCR_HUNDRED_YEARS_FIELD_LSB +: 7]};
	assign w_year = wm[RTCR_YEAR_LSB +: 8];
	assign w_month = {3'h0, wm[RTCR_MONTH_LSB +: 5]};
	assign w_dow = wm[RTCR_DOW_LSB +: 3];
	assign w_date = {2'h0, wm[RTCR_DATE_LSB +: 6]};
	assign time_ok = in_rng(w_sec, RTCR_BCD_00, RTCR_BCD_59) && in_rng(w_min, RTCR_BCD_00, RTCR_BCD_59)
		&& hour_ok(w_hour, wm[RTCR_PM_BIT], hr12_ff);
	assign cal_ok = (w_hundred_years_field == RTCR_BCD_20) && bcd_ok(w_year)
		&& in_rng(w_month, RTCR_BCD_01, RTCR_BCD_12)
		&& in_rng({5'h00, w_dow}, RTCR_BCD_01, RTCR_BCD_07)
		&& in_rng(w_date, RTCR_BCD_01, month_days(w_month, w_year));
	assign talm_ok = time_ok;
	assign dalm_ok = in_rng(w_month, RTCR_BCD_01, RTCR_BCD_12) && in_rng(w_date, RTCR_BCD_01, RTCR_BCD_31);

	// Control, format and protection words
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			hr12_ff <= 1'b0;
			wp_ff <= 1'b0;
			upd_tim_ff <= 1'b0;
			upd_cal_ff <= 1'b0;
			tev_ff <= RTCR_TEV_MINUTE;
			cev_ff <= RTCR_CEV_WEEK;
		end else begin
			if (wr_mode) hr12_ff <= wm[RTCR_HR_BIT];
			if (wr_prot) wp_ff <= wm[RTCR_WP_BIT];
			if (wr_ctrl) begin
				upd_tim_ff <= wm[RTCR_UPDT_BIT];
				upd_cal_ff <= wm[RTCR_UPDC_BIT];
				tev_ff <= rtcr_tev_t'(wm[RTCR_TEV_LSB +: 2]);
				cev_ff <= rtcr_cev_t'(wm[RTCR_CEV_LSB +: 2]);
			end
		end
	end

	// Seconds divider; the tick is a one-cycle pulse
	logic tick_now;
	assign tick_now = div_ff == RTCR_CNT_W'(SEC_CYCLES - 1);
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			div_ff <= '0;
			tick_ff <= 1'b0;
		end else begin
			div_ff <= tick_now ? '0 : div_ff + RTCR_CNT_W'(1);
			tick_ff <= tick_now;
		end
	end

	// Advance terms; all carries resolve in the tick cycle
	logic time_run, sec_wrap, min_wrap, midnight, noon, day_roll, date_wrap, month_wrap;
	logic [7:0] adv_sec, adv_min, adv_hour, adv_date, adv_month, adv_year;
	logic [2:0] adv_dow;
	logic adv_pm;
	assign time_run = tick_ff & !upd_tim_ff; // Time request freezes both halves
	assign sec_wrap = sec_ff == RTCR_BCD_59;
	assign min_wrap = sec_wrap & (min_ff == RTCR_BCD_59);
	assign adv_sec = sec_wrap ? RTCR_BCD_00 : bcd_inc(sec_ff);
	assign adv_min = !sec_wrap ? min_ff : (min_ff == RTCR_BCD_59) ? RTCR_BCD_00 : bcd_inc(min_ff);
	assign adv_hour = !min_wrap ? hour_ff
		: hr12_ff ? ((hour_ff == RTCR_BCD_12) ? RTCR_BCD_01 : bcd_inc(hour_ff))
		: ((hour_ff == RTCR_BCD_23) ? RTCR_BCD_00 : bcd_inc(hour_ff));
	assign adv_pm = pm_ff ^ (min_wrap & hr12_ff & hour_ff == RTCR_BCD_11);
	assign midnight = min_wrap & (hr12_ff ? (hour_ff == RTCR_BCD_11 & pm_ff) : hour_ff == RTCR_BCD_23);
	assign noon = min_wrap & (hr12_ff ? (hour_ff == RTCR_BCD_11 & !pm_ff) : hour_ff == RTCR_BCD_11);
	assign day_roll = time_run & !upd_cal_ff & midnight;
	assign date_wrap = date_ff == month_days(month_ff, year_ff);
	assign month_wrap = date_wrap & (month_ff == RTCR_BCD_12);
	assign adv_date = date_wrap ? RTCR_BCD_01 : bcd_inc(date_ff);
	assign adv_month = !date_wrap ? month_ff : month_wrap ? RTCR_BCD_01 : bcd_inc(month_ff);
	assign adv_year = !month_wrap ? year_ff : (year_ff == RTCR_BCD_99) ? RTCR_BCD_00 : bcd_inc(year_ff);
	assign adv_dow = (dow_ff == RTCR_BCD_07[2:0]) ? RTCR_BCD_01[2:0] : dow_ff + 3'h1;

	// Time counters: a granted write wins over the tick
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sec_ff <= RTCR_BCD_00;
			min_ff <= RTCR_BCD_00;
			hour_ff <= RTCR_BCD_00;
			pm_ff <= 1'b0;
		end else if (wr_time && time_ok) begin
			sec_ff <= w_sec;
			min_ff <= w_min;
			hour_ff <= w_hour;
			pm_ff <= wm[RTCR_PM_BIT];
		end else if (time_run) begin
			sec_ff <= adv_sec;
			min_ff <= adv_min;
			hour_ff <= adv_hour;
			pm_ff <= adv_pm;
		end
	end

	// Calendar counters
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			hundred_years_field_ff <= {1'b0, RTCR_RST_CAL[RTCR_HUNDRED_YEARS_FIELD_LSB +: 7]};
			year_ff <= RTCR_RST_CAL[RTCR_YEAR_LSB +: 8];
			month_ff <= {3'h0, RTCR_RST_CAL[RTCR_MONTH_LSB +: 5]};
			dow_ff <= RTCR_RST_CAL[RTCR_DOW_LSB +: 3];
			date_ff <= {2'h0, RTCR_RST_CAL[RTCR_DATE_LSB +: 6]};
		end else if (wr_cal && cal_ok) begin
			hundred_years_field_ff <= w_hundred_years_field;
			year_ff <= w_year;
			month_ff <= w_month;
			dow_ff <= w_dow;
			date_ff <= w_date;
		end else if (day_roll) begin
			year_ff <= adv_year;
			month_ff <= adv_month;
			dow_ff <= adv_dow;
			date_ff <= adv_date;
		end
	end

	// Alarm words and validity flags; a bad value leaves the old one in place
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			talm_ff <= 32'h00000000;
			dalm_ff <= RTCR_RST_DALM;
			nv_ff <= 4'h0;
		end else begin
			if (wr_talm && talm_ok) talm_ff <= wm & RTCR_TALM_MASK;
			if (wr_dalm && dalm_ok) dalm_ff <= wm & RTCR_DALM_MASK;
			if (wr_time) nv_ff[RTCR_NV_TIM] <= !time_ok;
			if (wr_cal) nv_ff[RTCR_NV_CAL] <= !cal_ok;
			if (wr_talm) nv_ff[RTCR_NV_TALM] <= !talm_ok;
			if (wr_dalm) nv_ff[RTCR_NV_DALM] <= !dalm_ok;
		end
	end

	// Alarm compare on the counters as they stand after a tick
	logic m_sec, m_min, m_hour, m_date, m_month, any_en, alarm_hit;
	assign m_sec = !talm_ff[RTCR_SEC_EN] || talm_ff[RTCR_SEC_LSB +: 7] == sec_ff[6:0];
	assign m_min = !talm_ff[RTCR_MIN_EN] || talm_ff[RTCR_MIN_LSB +: 7] == min_ff[6:0];
	assign m_hour = !talm_ff[RTCR_HOUR_EN]
		|| {talm_ff[RTCR_PM_BIT], talm_ff[RTCR_HOUR_LSB +: 6]} == {pm_ff, hour_ff[5:0]};
	assign m_date = !dalm_ff[RTCR_DATE_EN] || dalm_ff[RTCR_DATE_LSB +: 6] == date_ff[5:0];
	assign m_month = !dalm_ff[RTCR_MTH_EN] || dalm_ff[RTCR_MONTH_LSB +: 5] == month_ff[4:0];
	assign any_en = talm_ff[RTCR_SEC_EN] | talm_ff[RTCR_MIN_EN] | talm_ff[RTCR_HOUR_EN]
		| dalm_ff[RTCR_DATE_EN] | dalm_ff[RTCR_MTH_EN];
	assign alarm_hit = any_en & m_sec & m_min & m_hour & m_date & m_month;

	// Event selection
	logic tev_hit, cev_hit, grant_set, alm_chk_ff;
	assign tev_hit = time_run & ((tev_ff == RTCR_TEV_MINUTE) ? sec_wrap
		: (tev_ff == RTCR_TEV_HOUR) ? min_wrap
		: (tev_ff == RTCR_TEV_MIDNIGHT) ? midnight : noon);
	assign cev_hit = day_roll & ((cev_ff == RTCR_CEV_WEEK) ? dow_ff == RTCR_BCD_07[2:0]
		: (cev_ff == RTCR_CEV_MONTH) ? date_wrap
		: (cev_ff == RTCR_CEV_YEAR) ? month_wrap : 1'b0);
	assign grant_set = tick_ff & (upd_tim_ff | upd_cal_ff) & !granted_ff;

	// Sticky status; a set in the clearing cycle wins
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			granted_ff <= 1'b0;
			alm_chk_ff <= 1'b0;
			ack_ff <= 1'b0;
			alm_ff <= 1'b0;
			secf_ff <= 1'b0;
			tevf_ff <= 1'b0;
			cevf_ff <= 1'b0;
		end else begin
			granted_ff <= (granted_ff | grant_set) & (upd_tim_ff | upd_cal_ff);
			alm_chk_ff <= tick_ff;
			ack_ff <= grant_set | (ack_ff & !(wr_clr & wm[RTCR_ST_ACK]));
			alm_ff <= (alm_chk_ff & alarm_hit) | (alm_ff & !(wr_clr & wm[RTCR_ST_ALM]));
			secf_ff <= tick_ff | (secf_ff & !(wr_clr & wm[RTCR_ST_SEC]));
			tevf_ff <= tev_hit | (tevf_ff & !(wr_clr & wm[RTCR_ST_TEV]));
			cevf_ff <= cev_hit | (cevf_ff & !(wr_clr & wm[RTCR_ST_CEV]));
		end
	end

	assign axi_awready_o = awready_ff;
	assign axi_wready_o = wready_ff;
	assign axi_bvalid_o = bvalid_ff;
	assign axi_bresp_o = bresp_ff;
	assign axi_arready_o = arready_ff;
	assign axi_rvalid_o = rvalid_ff;
	assign axi_rdata_o = rdata_ff;
	assign axi_rresp_o = rresp_ff;
endmodule : rtcr_regs
`default_nettype wire

// ==== verif/rtcr_props.sv ====
// Checker for register port timing and read-back field shapes.
// Assumes binding to rtcr_regs: one clock, async active-high reset.
`default_nettype none
module rtcr_props
	import rtcr_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic axi_awvalid_i,
	input wire logic axi_awready_o,
	input wire logic axi_wvalid_i,
	input wire logic axi_wready_o,
	input wire logic [1:0] axi_bresp_o,
	input wire logic axi_bvalid_o,
	input wire logic axi_bready_i,
	input wire logic [31:0] axi_araddr_i,
	input wire logic axi_arvalid_i,
	input wire logic axi_arready_o,
	input wire logic [31:0] axi_rdata_o,
	input wire logic axi_rvalid_o,
	input wire logic axi_rready_i
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	// Read taken this edge; address still valid on the bus
	wire rd_go = axi_arvalid_i && axi_arready_o;
	property p_b_hold;
		axi_bvalid_o && !axi_bready_i |=> axi_bvalid_o && $stable(axi_bresp_o);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_r_hold;
		axi_rvalid_o && !axi_rready_i |=> axi_rvalid_o && $stable(axi_rdata_o);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	property p_r_lat;
		rd_go |=> axi_rvalid_o && !axi_arready_o;
	endproperty
	a_r_lat: assert property (p_r_lat) else $error("read answer late");
	property p_b_lat;
		axi_awvalid_i && axi_awready_o && axi_wvalid_i && axi_wready_o |=> !axi_bvalid_o ##1 axi_bvalid_o;
	endproperty
	a_b_lat: assert property (p_b_lat) else $error("write answer off time");
	property p_ar_back;
		axi_rvalid_o && axi_rready_i |=> !axi_rvalid_o ##1 axi_arready_o;
	endproperty
	a_ar_back: assert property (p_ar_back) else $error("read ready not back");
	property p_stat;
		rd_go && axi_araddr_i == RTCR_OFF_STAT |=> axi_rdata_o[31:5] == 27'h0;
	endproperty
	a_stat: assert property (p_stat) else $error("status spare bits set");
	property p_hundred_years_field;
		rd_go && axi_araddr_i == RTCR_OFF_CAL |=> axi_rdata_o[7:0] == 8'h20;
	endproperty
	a_hundred_years_field: assert property (p_hundred_years_field) else $error("century not 20");
	property p_time;
		rd_go && axi_araddr_i == RTCR_OFF_TIME |=>
			axi_rdata_o[7:0] <= 8'h59 && axi_rdata_o[15:8] <= 8'h59 && axi_rdata_o[21:16] <= 6'h23;
	endproperty
	a_time: assert property (p_time) else $error("time out of range");
endmodule : rtcr_props
bind rtcr_regs rtcr_props u_props (
	.ref_clk_i(ref_clk_i), .rst_i(rst_i), .axi_awvalid_i(axi_awvalid_i), .axi_awready_o(axi_awready_o),
	.axi_wvalid_i(axi_wvalid_i), .axi_wready_o(axi_wready_o), .axi_bresp_o(axi_bresp_o),
	.axi_bvalid_o(axi_bvalid_o), .axi_bready_i(axi_bready_i), .axi_araddr_i(axi_araddr_i),
	.axi_arvalid_i(axi_arvalid_i), .axi_arready_o(axi_arready_o), .axi_rdata_o(axi_rdata_o),
	.axi_rvalid_o(axi_rvalid_o), .axi_rready_i(axi_rready_i)
);
`default_nettype wire

// ==== verif/tb_rtcr_regs.sv ====
// Self-checking bench for the clock/calendar register block.
// Assumes the AXI4-Lite port and a second tick shortened to 40 cycles.
`default_nettype none
module tb_rtcr_regs
	import rtcr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst = 1, aw = 0, w = 0, b = 0, ar = 0, r = 0;
	logic awrdy, wrdy, bv, arrdy, rv;
	logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
	logic [1:0] bresp, rresp;
	int n_fail = 0, n_compared = 0;
	rtcr_regs #(.SEC_CYCLES(40)) dut (.ref_clk_i(clk), .rst_i(rst), .axi_awaddr_i(awaddr), .axi_awvalid_i(aw),
		.axi_awready_o(awrdy), .axi_wdata_i(wdata), .axi_wstrb_i(4'hF), .axi_wvalid_i(w), .axi_wready_o(wrdy),
		.axi_bresp_o(bresp), .axi_bvalid_o(bv), .axi_bready_i(b), .axi_araddr_i(araddr), .axi_arvalid_i(ar),
		.axi_arready_o(arrdy), .axi_rdata_o(rdata), .axi_rresp_o(rresp), .axi_rvalid_o(rv), .axi_rready_i(r));
	initial begin
		forever #20 clk = ~clk;
	end
	task automatic close_out;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : close_out
	task automatic hang;
		n_fail++;
		close_out();
	endtask : hang
	task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
		n_compared++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask : chk
	// Address and data offered together, each released when taken
	task automatic wr(input logic [31:0] a, d, input logic [1:0] er = RTCR_RESP_OKAY);
		bit done = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		aw <= 1'b1;
		w <= 1'b1;
		b <= 1'b1;
		for (int k = 0; k < 50 && !done; k++) begin
			@(posedge clk);
			if (aw && awrdy) aw <= 1'b0;
			if (w && wrdy) w <= 1'b0;
			if (bv) begin
				chk("bresp", {32'h0, er}, {32'h0, bresp});
				b <= 1'b0;
				done = 1;
			end
		end
		if (!done) hang();
	endtask : wr
	task automatic rd(input logic [31:0] a, output logic [33:0] q);
		bit done = 0;
		@(posedge clk);
		araddr <= a;
		ar <= 1'b1;
		r <= 1'b1;
		for (int k = 0; k < 50 && !done; k++) begin
			@(posedge clk);
			if (ar && arrdy) ar <= 1'b0;
			if (rv) begin
				q = {rresp, rdata};
				r <= 1'b0;
				done = 1;
			end
		end
		if (!done) hang();
	endtask : rd
	task automatic rc(input string nm, input logic [31:0] a, e, m = 32'hFFFFFFFF, input logic [1:0] er = 2'h0);
		logic [33:0] q;
		rd(a, q);
		chk(nm, {er, e & m}, {q[33:32], q[31:0] & m});
	endtask : rc
	// Status polling; a tick is at most 40 cycles away
	task automatic poll(input int bi);
		logic [33:0] q;
		for (int k = 0; k < 100; k++) begin
			rd(RTCR_OFF_STAT, q);
			if (q[bi] === 1'b1) return;
		end
		hang();
	endtask : poll
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rc("status", RTCR_OFF_STAT, 32'h0);
		rc("mode", RTCR_OFF_MODE, 32'h0);
		rc("time", RTCR_OFF_TIME, 32'h0);
		rc("cal", RTCR_OFF_CAL, RTCR_RST_CAL);
		rc("talm", RTCR_OFF_TALM, 32'h0);
		rc("dalm", RTCR_OFF_DALM, RTCR_RST_DALM);
		rc("hole", 32'h0FFFFF00, 32'h0, 32'hFFFFFFFF, RTCR_RESP_SLVERR);
		wr(32'h0FFFFF00, 32'h1, RTCR_RESP_SLVERR);
		// Protection holds back format and alarm writes
		wr(RTCR_OFF_PROT, 32'h1);
		wr(RTCR_OFF_MODE, 32'h1);
		wr(RTCR_OFF_TALM, 32'h00A3D9D9);
		rc("mode prot", RTCR_OFF_MODE, 32'h0);
		rc("talm prot", RTCR_OFF_TALM, 32'h0);
		wr(RTCR_OFF_PROT, 32'h0);
		wr(RTCR_OFF_MODE, 32'h1);
		rc("mode", RTCR_OFF_MODE, 32'h1);
		wr(RTCR_OFF_MODE, 32'h0);
		// Good alarm loads, bad one is held off and flagged
		wr(RTCR_OFF_TALM, 32'h00A3D9D9);
		wr(RTCR_OFF_TALM, 32'h00800060);
		rc("talm", RTCR_OFF_TALM, 32'h00A3D9D9);
		rc("valid talm", RTCR_OFF_VALID, 32'h4, 32'h4);
		wr(RTCR_OFF_DALM, 32'h81920000);
		rc("dalm", RTCR_OFF_DALM, 32'h81920000);
		wr(RTCR_OFF_DALM, 32'h01120000);
		// Stop both counters, wait for the grant
		wr(RTCR_OFF_CTRL, 32'h3);
		poll(RTCR_ST_ACK);
		wr(RTCR_OFF_CLR, 32'h1);
		rc("grant clr", RTCR_OFF_STAT, 32'h0, 32'h1);
		wr(RTCR_OFF_CAL, 32'h31F22419);
		rc("valid cal", RTCR_OFF_VALID, 32'h2, 32'h2);
		wr(RTCR_OFF_CAL, 32'h31F22420);
		wr(RTCR_OFF_TIME, 32'h00235959);
		wr(RTCR_OFF_TIME, 32'h00635959);
		rc("valid time", RTCR_OFF_VALID, 32'h1, 32'h1);
		rc("cal", RTCR_OFF_CAL, 32'h31F22420);
		rc("time", RTCR_OFF_TIME, 32'h00235959);
		// Second tick still flags while counters are stopped; held time matches alarm
		wr(RTCR_OFF_CLR, 32'h1F);
		poll(RTCR_ST_SEC);
		rc("stat stop", RTCR_OFF_STAT, 32'h6, 32'h1E);
		// Resume right after a tick so the next one rolls the day; midnight and year events chosen
		wr(RTCR_OFF_TALM, 32'h00235959);
		wr(RTCR_OFF_CLR, 32'h1F);
		wr(RTCR_OFF_CTRL, 32'h00020200);
		poll(RTCR_ST_SEC);
		rc("time roll", RTCR_OFF_TIME, 32'h0);
		rc("cal roll", RTCR_OFF_CAL, 32'h01212520);
		rc("events", RTCR_OFF_STAT, 32'h1C, 32'h1E);
		wr(RTCR_OFF_CLR, 32'h0);
		rc("clr zero", RTCR_OFF_STAT, 32'h18, 32'h18);
		wr(RTCR_OFF_CLR, 32'h18);
		rc("clr ev", RTCR_OFF_STAT, 32'h0, 32'h18);
		close_out();
	end
	// Watchdog against a hung handshake
	initial begin
		repeat (100000) @(posedge clk);
		hang();
	end
endmodule : tb_rtcr_regs
`default_nettype wire
